// [hw/hdp_pkg.sv]
`default_nettype none
package hdp_pkg;
  // Clock period of the host logic in nanoseconds.
  localparam int CLK_PERIOD_NS = 4;

  // Pin timing targets in nanoseconds, kept above the panel's minimum figures.
  localparam int SETUP_NS       = 12;
  localparam int STROBE_NS      = 200;
  localparam int HOLD_NS        = 20;
  localparam int RECOVER_NS     = 100;
  localparam int SCLK_LOW_NS    = 100;
  localparam int SCLK_HIGH_NS   = 200;
  localparam int PANEL_RESET_NS = 2000;

  // Cycle counts, rounded up so that no interval falls short but the serial clock low, which gets one cycle less.
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] CNT_SETUP =
    TMR_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CNT_STROBE =
    TMR_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CNT_HOLD =
    TMR_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CNT_RECOVER =
    TMR_W'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CNT_SCLK_LOW =
    TMR_W'((SCLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CNT_SCLK_HIGH =
    TMR_W'((SCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CNT_PANEL_RESET =
    TMR_W'((PANEL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Request queue layout: {read, data_command_select, byte}.
  localparam int BYTE_W      = 8;
  localparam int ENT_W       = 10;
  localparam int ENT_READ    = 9;
  localparam int ENT_DC      = 8;
  localparam int FIFO_DEPTH  = 32;
  localparam int SER_CLK_BIT = 0;
  localparam int SER_DAT_BIT = 1;

  // Bus mode that the panel's straps select.
  typedef enum logic [1:0] {
    HDP_MODE_6800 = 2'h0,
    HDP_MODE_8080 = 2'h1,
    HDP_MODE_SPI  = 2'h2
  } hdp_mode_t;

  // Transfer sequencer states.
  typedef enum logic [2:0] {
    ST_PANEL_RESET = 3'h0,
    ST_IDLE        = 3'h1,
    ST_SETUP       = 3'h2,
    ST_ACTIVE      = 3'h3,
    ST_HOLD        = 3'h4,
    ST_RECOVER     = 3'h5,
    ST_SER_LOW     = 3'h6,
    ST_SER_HIGH    = 3'h7
  } hdp_state_t;
endpackage
`default_nettype wire

// [hw/hdp_stream_if.sv]
`default_nettype none
// Valid and ready word stream between the queue and the sequencer.
interface hdp_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// [hw/hdp_fifo.sv]
`default_nettype none
module hdp_fifo
  import hdp_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  hdp_stream_if.source      out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          nonempty;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign out.valid = nonempty;
  assign out.data  = mem[rd_ptr];

  // Ready and nonempty are registered so the top sees clean flop outputs.
  always_comb begin
    push        = in_valid && in_ready;
    pop         = nonempty && out.ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage is written only on an accepted push.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
      nonempty <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      nonempty <= next_count != '0;
      if (push) begin
        mem[wr_ptr] <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/hdp_host_port.sv]
`default_nettype none
// Function
// - The eight data lines are driven by the host on writes and released to the panel on reads.
// - In serial mode line 1 carries the serial data and line 0 the serial clock from the host.
// - In 6800 mode the read pin is the enable, raised with select low to start a transfer.
// - In 6800 mode the write pin is high for a read cycle and low for a write cycle.
// - In 8080 mode a read starts when the read pin goes low with select low.
// - In 8080 mode a write starts when the write pin goes low with select low.
// - In the parallel modes the host makes one discarded dummy read before the first display memory read after reset or after any write.
module hdp_host_port
  import hdp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [1:0]        bus_mode,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_read,
  input  wire logic              cmd_dc,
  input  wire logic [BYTE_W-1:0] cmd_byte,
  output var  logic              cmd_ready,
  output var  logic              rsp_valid,
  output var  logic [BYTE_W-1:0] rsp_byte,
  output var  logic              busy,
  input  wire logic [BYTE_W-1:0] host_data_bus_in,
  output var  logic [BYTE_W-1:0] host_data_bus_out,
  output var  logic              host_data_bus_oe,
  output var  logic              enable_read_pin,
  output var  logic              select_write_pin,
  output var  logic              chip_select_n,
  output var  logic              data_command_select,
  output var  logic              panel_reset_n
);
  logic              rst_meta_n;
  logic              rst_sync_n;
  logic [BYTE_W-1:0] din_meta;
  logic [BYTE_W-1:0] din_sync;
  logic [1:0]        mode_meta;
  logic [1:0]        mode_sync;

  hdp_stream_if #(.W(ENT_W)) q ();

  hdp_fifo #(.W(ENT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .in_valid (cmd_valid),
    .in_data  ({cmd_read, cmd_dc, cmd_byte}),
    .in_ready (cmd_ready),
    .out      (q.source)
  );

  // Reset release is synchronised so every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Pin inputs pass two flops; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      din_meta  <= '0;
      din_sync  <= '0;
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      din_meta  <= host_data_bus_in;
      din_sync  <= din_meta;
      mode_meta <= bus_mode;
      mode_sync <= mode_meta;
    end
  end

  hdp_state_t        state;
  hdp_state_t        next_state;
  logic [TMR_W-1:0]  timer;
  logic [TMR_W-1:0]  next_timer;
  hdp_mode_t         mode;
  hdp_mode_t         next_mode;
  logic [ENT_W-1:0]  entry;
  logic [ENT_W-1:0]  next_entry;
  logic [2:0]        bit_idx;
  logic [2:0]        next_bit_idx;
  logic              dummy_pending;
  logic              next_dummy_pending;
  logic              is_dummy;
  logic              next_is_dummy;
  logic              next_rsp_valid;
  logic [BYTE_W-1:0] next_rsp_byte;
  logic              next_busy;
  logic [BYTE_W-1:0] next_dout;
  logic              next_oe;
  logic              next_erd;
  logic              next_swr;
  logic              next_cs_n;
  logic              next_dc;
  logic              next_panel_reset_n;
  logic              tmr_done;

  // The panel's straps decide its mode; the host only mirrors them.
  assign q.ready  = (state == ST_IDLE) && !(q.data[ENT_READ] && q.data[ENT_DC]
                    && dummy_pending && hdp_mode_t'(mode_sync) != HDP_MODE_SPI);
  assign tmr_done = timer == TMR_W'(1);

  // Sequencer next state: one bus transfer per queue entry, plus a dummy read where one is due; serial reads make none.
  always_comb begin
    next_state         = state;
    next_timer         = tmr_done ? timer : timer - 1'b1;
    next_mode          = mode;
    next_entry         = entry;
    next_bit_idx       = bit_idx;
    next_dummy_pending = dummy_pending;
    next_is_dummy      = is_dummy;
    next_rsp_valid     = 1'b0;
    next_rsp_byte      = rsp_byte;
    next_busy          = busy;
    next_dout          = host_data_bus_out;
    next_oe            = host_data_bus_oe;
    next_erd           = enable_read_pin;
    next_swr           = select_write_pin;
    next_cs_n          = chip_select_n;
    next_dc            = data_command_select;
    next_panel_reset_n = panel_reset_n;
    unique case (state)
      ST_PANEL_RESET: begin
        if (tmr_done) begin
          next_panel_reset_n = 1'b1;
          next_timer         = CNT_RECOVER;
          next_state         = ST_RECOVER;
        end
      end
      ST_IDLE: begin
        next_busy = q.valid;
        // The enable rests at the strapped mode's idle level while select is high.
        // The first edge then moves no strobe with select, except in a transfer begun on the first idle cycle after reset in 6800 or after a change to or from 6800.
        next_erd  = hdp_mode_t'(mode_sync) != HDP_MODE_6800;
        if (q.valid) begin
          next_mode     = hdp_mode_t'(mode_sync);
          next_entry    = q.data;
          next_is_dummy = !q.ready;
          next_dc       = q.data[ENT_DC];
          next_timer    = CNT_SETUP;
          next_busy     = 1'b1;
          if (!q.data[ENT_READ]) begin
            next_dummy_pending = 1'b1;
          end else if (q.data[ENT_DC]) begin
            next_dummy_pending = 1'b0;
          end
          if (hdp_mode_t'(mode_sync) == HDP_MODE_SPI) begin
            if (q.data[ENT_READ]) begin
              // The serial link has no read path, so a read answers zero at once.
              next_rsp_valid = 1'b1;
              next_rsp_byte  = '0;
            end else begin
              next_cs_n    = 1'b0;
              next_oe      = 1'b1;
              next_bit_idx = 3'h7;
              next_timer   = CNT_SCLK_LOW;
              next_state   = ST_SER_LOW;
            end
          end else begin
            next_cs_n = 1'b0;
            next_oe   = !q.data[ENT_READ];
            next_dout = q.data[BYTE_W-1:0];
            if (hdp_mode_t'(mode_sync) == HDP_MODE_6800) begin
              next_swr = q.data[ENT_READ];
              next_erd = 1'b0;
            end else begin
              next_swr = 1'b1;
              next_erd = 1'b1;
            end
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          if (mode == HDP_MODE_6800) begin
            next_erd = 1'b1;
          end else if (entry[ENT_READ]) begin
            next_erd = 1'b0;
          end else begin
            next_swr = 1'b0;
          end
          next_timer = CNT_STROBE;
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (tmr_done) begin
          // Read data is taken before the strobe ends, while the panel still drives it.
          if (entry[ENT_READ] && !is_dummy) begin
            next_rsp_byte = din_sync;
          end
          // Ending the strobe gives the latch edge the panel needs.
          next_erd   = mode != HDP_MODE_6800;
          next_swr   = (mode == HDP_MODE_6800) ? select_write_pin : 1'b1;
          next_timer = CNT_HOLD;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          next_cs_n      = 1'b1;
          next_oe        = 1'b0;
          next_swr       = 1'b1;
          next_dout      = '0;
          next_rsp_valid = entry[ENT_READ] && !is_dummy;
          next_timer     = CNT_RECOVER;
          next_state     = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Select stays high long enough to meet the panel's minimum high width.
        if (tmr_done) begin
          // Busy stays up while work is queued, so a waiter sees no gap between bytes.
          next_busy  = q.valid;
          next_state = ST_IDLE;
        end
      end
      ST_SER_LOW: begin
        next_dout[SER_CLK_BIT] = 1'b0;
        next_dout[SER_DAT_BIT] = entry[bit_idx];
        if (tmr_done) begin
          next_dout[SER_CLK_BIT] = 1'b1;
          next_timer             = CNT_SCLK_HIGH;
          next_state             = ST_SER_HIGH;
        end
      end
      ST_SER_HIGH: begin
        if (tmr_done) begin
          next_bit_idx = bit_idx - 1'b1;
          next_timer   = (bit_idx == 3'h0) ? CNT_HOLD : CNT_SCLK_LOW;
          next_state   = (bit_idx == 3'h0) ? ST_HOLD : ST_SER_LOW;
        end
      end
    endcase
  end

  // Sequencer registers; the panel is held in reset first, so the pins start quiet.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state               <= ST_PANEL_RESET;
      timer               <= CNT_PANEL_RESET;
      mode                <= HDP_MODE_6800;
      entry               <= '0;
      bit_idx             <= 3'h7;
      dummy_pending       <= 1'b1;
      is_dummy            <= 1'b0;
      rsp_valid           <= 1'b0;
      rsp_byte            <= '0;
      busy                <= 1'b1;
      host_data_bus_out   <= '0;
      host_data_bus_oe    <= 1'b0;
      enable_read_pin     <= 1'b1;
      select_write_pin    <= 1'b1;
      chip_select_n       <= 1'b1;
      data_command_select <= 1'b1;
      panel_reset_n       <= 1'b0;
    end else begin
      state               <= next_state;
      timer               <= next_timer;
      mode                <= next_mode;
      entry               <= next_entry;
      bit_idx             <= next_bit_idx;
      dummy_pending       <= next_dummy_pending;
      is_dummy            <= next_is_dummy;
      rsp_valid           <= next_rsp_valid;
      rsp_byte            <= next_rsp_byte;
      busy                <= next_busy;
      host_data_bus_out   <= next_dout;
      host_data_bus_oe    <= next_oe;
      enable_read_pin     <= next_erd;
      select_write_pin    <= next_swr;
      chip_select_n       <= next_cs_n;
      data_command_select <= next_dc;
      panel_reset_n       <= next_panel_reset_n;
    end
  end
endmodule
`default_nettype wire

// [verification/hdp_host_port_assertions.sv]
`default_nettype none
module hdp_host_port_assertions
  import hdp_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [1:0]        bus_mode,
  input wire logic              rsp_valid,
  input wire logic [BYTE_W-1:0] host_data_bus_out,
  input wire logic              host_data_bus_oe,
  input wire logic              enable_read_pin,
  input wire logic              select_write_pin,
  input wire logic              chip_select_n,
  input wire logic              data_command_select,
  input wire logic              panel_reset_n
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mode decodes; the mode only changes while the port is idle.
  wire logic m68 = bus_mode == 2'h0;
  wire logic m80 = bus_mode == 2'h1;
  wire logic msr = bus_mode == 2'h2;
  // Pin relations that the panel relies on.
  AST_RD_SEL: assert property (m80 && !enable_read_pin |-> !chip_select_n)
    else $error("read strobe without select");
  AST_WR_SEL: assert property (m80 && !select_write_pin |-> !chip_select_n)
    else $error("write strobe without select");
  AST_RD_FREE: assert property (m80 && !enable_read_pin |-> !host_data_bus_oe)
    else $error("bus driven during read");
  AST_WR_LATCH: assert property (m80 && $rose(select_write_pin) && !chip_select_n |->
      host_data_bus_oe && $stable(host_data_bus_out) && $stable(data_command_select))
    else $error("write latch unstable");
  AST_E_LATCH: assert property ($fell(enable_read_pin) && !$past(chip_select_n) |->
      !chip_select_n && $stable(select_write_pin) && $stable(data_command_select))
    else $error("enable fall unstable");
  AST_E_DRIVE: assert property (m68 && !chip_select_n && !select_write_pin |-> host_data_bus_oe)
    else $error("write cycle with bus released");
  AST_INIT_QUIET: assert property (!panel_reset_n |-> chip_select_n && !rsp_valid)
    else $error("traffic during panel reset");
  AST_SER_BIT: assert property (msr && !chip_select_n && $rose(host_data_bus_out[0]) |->
      host_data_bus_oe && $stable(host_data_bus_out[1]))
    else $error("serial data moved at clock rise");
endmodule
`default_nettype wire

// [verification/hdp_panel_model.sv]
`default_nettype none
module hdp_panel_model (
  input  wire logic [1:0] strap,
  input  wire logic       cs_n,
  input  wire logic       erd,
  input  wire logic       swr,
  input  wire logic       dc,
  input  wire logic       res_n,
  input  wire logic [7:0] bus,
  output wire logic [7:0] drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wr_byte;
  logic [7:0] sh;
  logic [7:0] rd_val = 8'ha0;
  logic [7:0] last   = 8'h00;
  logic       wr_dc;
  int         n_wr, n_rd, nb;
  realtime    t_sel;
  // Traffic counts only after initialisation and while selected.
  wire logic live  = res_n === 1'b1 && cs_n === 1'b0;
  // The strap setting alone decides what the strobes mean.
  wire logic rd_on = live && (strap == 2'h1 ? !erd : strap == 2'h0 && erd && swr);
  // A released bus shows the inverse of the last byte, so a stale read cannot pass.
  assign drv = rd_on ? rd_val : ~last;
  task automatic take(input logic [7:0] b);
    wr_byte = b;
    wr_dc   = dc;
    n_wr++;
  endtask
  // Parallel writes latch on the strobe edge of the strapped mode.
  always @(posedge swr) if (live && strap == 2'h1) take(bus);
  always @(negedge erd) if (live && strap == 2'h0 && !swr) take(bus);
  // Each read moves the internal pipeline on by one byte.
  always @(negedge rd_on) if (res_n === 1'b1) begin
    last = rd_val;
    rd_val++;
    n_rd++;
  end
  // Serial bits come MSB first; sampling late keeps clear of the select edge.
  always @(negedge cs_n) begin
    t_sel = $realtime;
    nb    = 0;
  end
  always @(posedge bus[0]) begin
    #1;
    if (live && strap == 2'h2 && $realtime - t_sel > 2.0) begin
      sh = {sh[6:0], bus[1]};
      nb++;
      if (nb == 8) take(sh);
    end
  end
endmodule
`default_nettype wire

// [verification/tb_hdp_host_port.sv]
`default_nettype none
module tb_hdp_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk        = 1'b0;
  logic       rst_n      = 1'b0;
  logic [1:0] bus_mode   = 2'h1;
  logic       cmd_valid  = 1'b0;
  logic       cmd_read   = 1'b0;
  logic       cmd_dc     = 1'b0;
  logic [7:0] cmd_byte   = 8'h00;
  logic [7:0] got[$];
  int         n_mismatch = 0;
  int         checked    = 0;
  wire logic       cmd_ready, rsp_valid, busy, oe, erd, swr, cs_n, dc, pres_n;
  wire logic [7:0] rsp_byte, hout, drv, bus_in;
  // The host wins the wire while its enable is high.
  assign bus_in = oe ? hout : drv;
  always #2 clk = ~clk;
  hdp_host_port uut (
    .clk(clk), .rst_n(rst_n), .bus_mode(bus_mode), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_dc(cmd_dc), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .busy(busy), .host_data_bus_in(bus_in),
    .host_data_bus_out(hout), .host_data_bus_oe(oe), .enable_read_pin(erd),
    .select_write_pin(swr), .chip_select_n(cs_n), .data_command_select(dc),
    .panel_reset_n(pres_n)
  );
  hdp_panel_model pm (
    .strap(bus_mode), .cs_n(cs_n), .erd(erd), .swr(swr), .dc(dc), .res_n(pres_n),
    .bus(bus_in), .drv(drv)
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Every answer is logged at the falling edge, whichever task is running.
  always @(negedge clk) if (rsp_valid === 1'b1) got.push_back(rsp_byte);
  // Waits for the port to go idle; a hang ends the run.
  task automatic wait_idle;
    int i;
    repeat (3) @(negedge clk);
    for (i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge clk);
    if (i == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // Leaves valid high so back-to-back requests never toggle it in one step.
  task automatic push(input logic rd, input logic d, input logic [7:0] b);
    int i;
    cmd_read  = rd;
    cmd_dc    = d;
    cmd_byte  = b;
    cmd_valid = 1'b1;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i == 100) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(negedge clk);
  endtask
  task automatic t_reset;
    check("panel_reset_n", pres_n, 0);
    check("cs_n", cs_n, 1);
  endtask
  // Fills the queue while the panel initialises, then drains it.
  task automatic t_fill;
    int n;
    n = 0;
    repeat (40) begin
      cmd_byte  = n[7:0];
      cmd_valid = 1'b1;
      if (cmd_ready === 1'b1) n++;
      @(negedge clk);
    end
    cmd_valid = 1'b0;
    check("accepted", n, 32);
    check("early writes", pm.n_wr, 0);
    wait_idle;
    check("panel_reset_n high", pres_n, 1);
    check("writes", pm.n_wr, 32);
    check("last byte", pm.wr_byte, 8'h1f);
    check("last dc", pm.wr_dc, 0);
  endtask
  task automatic t_write(input logic [1:0] m, input logic d, input logic [7:0] b);
    int w;
    bus_mode = m;
    repeat (4) @(negedge clk);
    w = pm.n_wr;
    push(1'b0, d, b);
    cmd_valid = 1'b0;
    wait_idle;
    check("writes", pm.n_wr, w + 1);
    check("byte", pm.wr_byte, b);
    check("dc", pm.wr_dc, d);
  endtask
  // Two data reads after a write, then a command read: one extra bus read, three answers.
  task automatic t_read(input logic [1:0] m);
    int r;
    logic [7:0] e;
    bus_mode = m;
    repeat (4) @(negedge clk);
    r = pm.n_rd;
    e = pm.rd_val;
    got = {};
    push(1'b1, 1'b1, 8'h00);
    push(1'b1, 1'b1, 8'h00);
    push(1'b1, 1'b0, 8'h00);
    cmd_valid = 1'b0;
    wait_idle;
    check("bus reads", pm.n_rd, r + 4);
    check("answers", got.size(), 3);
    check("first", got[0], e + 8'h01);
    check("second", got[1], e + 8'h02);
    check("status", got[2], e + 8'h03);
  endtask
  // Serial reads make no bus cycle and answer zero straight away.
  task automatic t_ser_read;
    int r;
    int w;
    r = pm.n_rd;
    w = pm.n_wr;
    got = {};
    push(1'b1, 1'b1, 8'h00);
    push(1'b1, 1'b0, 8'h00);
    cmd_valid = 1'b0;
    wait_idle;
    check("serial bus reads", pm.n_rd, r);
    check("serial bus writes", pm.n_wr, w);
    check("serial answers", got.size(), 2);
    check("serial first", got[0], 8'h00);
    check("serial second", got[1], 8'h00);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset;
    t_fill;
    t_write(2'h1, 1'b1, 8'h1d);
    t_read(2'h1);
    t_write(2'h0, 1'b0, 8'h2e);
    t_write(2'h0, 1'b1, 8'hb4);
    t_read(2'h0);
    t_write(2'h2, 1'b1, 8'h1d);
    t_write(2'h2, 1'b0, 8'h6b);
    t_ser_read;
    tally_and_finish;
  end
endmodule
bind hdp_host_port hdp_host_port_assertions chk (
  .clk(clk), .rst_n(rst_n), .bus_mode(bus_mode), .rsp_valid(rsp_valid),
  .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
  .enable_read_pin(enable_read_pin), .select_write_pin(select_write_pin),
  .chip_select_n(chip_select_n), .data_command_select(data_command_select),
  .panel_reset_n(panel_reset_n)
);
`default_nettype wire
